// >>> inc/ept_pkg.sv
package ept_pkg;
  // register byte addresses on the wishbone port
  localparam logic [3:0] EPT_ADDR_CTRL   = 4'h0;
  localparam logic [3:0] EPT_ADDR_COUNT  = 4'h4;
  localparam logic [3:0] EPT_ADDR_PERIOD = 4'h8;
  localparam logic [3:0] EPT_ADDR_STAT   = 4'hC;
  // interrupt block, same one-bit layout in each
  localparam logic [4:0] EPT_ADDR_IEN    = 5'h10;
  localparam logic [4:0] EPT_ADDR_ICLR   = 5'h14;
  // control field positions
  localparam int EPT_CKPS_LSB = 0;
  localparam int EPT_RUN_BIT  = 2;
  localparam int EPT_OUTPS_LSB = 3;
  localparam int EPT_CTRL_USED = 7;
  // reset values
  localparam logic [7:0] EPT_CTRL_RST   = 8'h00;
  localparam logic [7:0] EPT_COUNT_RST  = 8'h00;
  localparam logic [7:0] EPT_PERIOD_RST = 8'hFF;
  // prescale codes and terminal counts
  localparam logic [1:0] EPT_CKPS_DIV1 = 2'h0;
  localparam logic [1:0] EPT_CKPS_DIV4 = 2'h1;
  localparam logic [3:0] EPT_PRE_TC4   = 4'h3;
  localparam logic [3:0] EPT_PRE_TC16  = 4'hF;
  // instruction-cycle terminal count, four core clocks per cycle
  localparam logic [1:0] EPT_ICYC_TC   = 2'h3;
endpackage

// >>> rtl/ept_div.sv
// free divider: pulse when count reaches terminal, cleared by clr
module ept_div #(
  parameter int W = 4
) (
  // clock and reset
  input  wire logic         sys_clk,
  input  wire logic         srst,
  // control
  input  wire logic         clr,
  input  wire logic         inc,
  input  wire logic [W-1:0] tc,
  // result
  output logic              hit
);
  logic [W-1:0] cnt_reg;
  logic [W-1:0] cnt_next;

  assign hit      = inc && (cnt_reg >= tc);
  assign cnt_next = hit ? '0 : cnt_reg + W'(1);

  always_ff @(posedge sys_clk) begin
    if (srst || clr) begin
      cnt_reg <= '0;
    end else if (inc) begin
      cnt_reg <= cnt_next;
    end
  end
endmodule

// >>> rtl/ept_flag.sv
// sticky flag, set wins over clear
module ept_flag (
  // clock and reset
  input  wire logic sys_clk,
  input  wire logic srst,
  // events
  input  wire logic set,
  input  wire logic clr,
  // state
  output logic      flag
);
  logic flag_reg;

  assign flag = flag_reg;

  always_ff @(posedge sys_clk) begin
    if (srst) begin
      flag_reg <= 1'b0;
    end else if (set) begin
      flag_reg <= 1'b1;
    end else if (clr) begin
      flag_reg <= 1'b0;
    end
  end
endmodule

// >>> rtl/ept_timer.sv
// Notes on behaviour
// - eight-bit count and period registers, both software read and write
// - count input is core clock divided by four before prescaling
// - control bits 1:0 pick prescale 1:1, 1:4 or 1:16
// - control bits 6:3 divide matches by value plus one before flag
// - control bit 2 runs the timer; clear stops it
// - counter climbs from zero to period, then wraps to zero
// - period register resets to FFh
// - count register clears on any reset
// - scaler counters clear on count write, control write, reset
// - control write leaves count register unchanged
// - postscaler output sets flag; interrupt only while enabled
// - pre-postscaler match pulse drives pwm time base and postscaler input
module ept_timer
  import ept_pkg::*;
(
  // clock and reset
  input  wire logic        sys_clk,
  input  wire logic        srst,
  // wishbone slave
  input  wire logic        wb_cyc_i,
  input  wire logic        wb_stb_i,
  input  wire logic        wb_we_i,
  input  wire logic [4:0]  wb_adr_i,
  input  wire logic [3:0]  wb_sel_i,
  input  wire logic [31:0] wb_dat_i,
  output logic      [31:0] wb_dat_o,
  output logic             wb_ack_o,
  // time base and interrupt
  output logic             pwm_time_base,
  output logic             irq
);
  logic [7:0]  ctrl_reg;
  logic [7:0]  count_reg;
  logic [7:0]  count_next;
  logic [7:0]  period_reg;
  logic        ien_reg;
  logic        ack_reg;
  logic [31:0] rdat_reg;
  logic [31:0] rdat_next;
  logic        match_reg;
  logic        match_irq_flag;

  // bus decode
  wire req       = wb_cyc_i && wb_stb_i && !ack_reg;
  wire wr_lane0  = req && wb_we_i && wb_sel_i[0];
  wire sel_ctrl  = wb_adr_i == {1'b0, EPT_ADDR_CTRL};
  wire sel_count = wb_adr_i == {1'b0, EPT_ADDR_COUNT};
  wire sel_per   = wb_adr_i == {1'b0, EPT_ADDR_PERIOD};
  wire sel_stat  = wb_adr_i == {1'b0, EPT_ADDR_STAT};
  wire sel_ien   = wb_adr_i == EPT_ADDR_IEN;
  wire sel_iclr  = wb_adr_i == EPT_ADDR_ICLR;
  wire wr_ctrl   = wr_lane0 && sel_ctrl;
  wire wr_count  = wr_lane0 && sel_count;
  wire wr_per    = wr_lane0 && sel_per;
  wire wr_ien    = wr_lane0 && sel_ien;
  wire wr_iclr   = wr_lane0 && sel_iclr && wb_dat_i[0];

  // field views
  wire       timer_run        = ctrl_reg[EPT_RUN_BIT];
  wire [1:0] prescale_select  = ctrl_reg[EPT_CKPS_LSB +: 2];
  wire [3:0] postscale_select = ctrl_reg[EPT_OUTPS_LSB +: 4];

  wire scaler_clr = wr_ctrl || wr_count;

  // instruction-cycle tick, core clock over four
  wire icyc_tick;
  ept_div #(.W(2)) u_icyc (
    .sys_clk (sys_clk),
    .srst    (srst),
    .clr     (scaler_clr),
    .inc     (timer_run),
    .tc      (EPT_ICYC_TC),
    .hit     (icyc_tick)
  );

  wire [3:0] pre_tc = (prescale_select == EPT_CKPS_DIV1) ? 4'h0 :
                      (prescale_select == EPT_CKPS_DIV4) ? EPT_PRE_TC4 : EPT_PRE_TC16;
  wire inc_tick;
  ept_div #(.W(4)) u_pre (
    .sys_clk (sys_clk),
    .srst    (srst),
    .clr     (scaler_clr),
    .inc     (icyc_tick),
    .tc      (pre_tc),
    .hit     (inc_tick)
  );

  wire at_period = count_reg == period_reg;
  wire wrap      = inc_tick && at_period;
  assign count_next = wrap ? 8'h00 : count_reg + 8'h01;

  // postscaler divides matches by select plus one
  wire post_hit;
  ept_div #(.W(4)) u_post (
    .sys_clk (sys_clk),
    .srst    (srst),
    .clr     (scaler_clr),
    .inc     (wrap),
    .tc      (postscale_select),
    .hit     (post_hit)
  );

  ept_flag u_flag (
    .sys_clk (sys_clk),
    .srst    (srst),
    .set     (post_hit),
    .clr     (wr_iclr),
    .flag    (match_irq_flag)
  );

  assign irq = match_irq_flag && ien_reg;

  // one-clock time base pulse, before postscaler
  assign pwm_time_base = match_reg;

  always_ff @(posedge sys_clk) begin
    if (srst) begin
      match_reg <= 1'b0;
    end else begin
      match_reg <= wrap;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (srst) begin
      ctrl_reg <= EPT_CTRL_RST;
    end else if (wr_ctrl) begin
      ctrl_reg <= {1'b0, wb_dat_i[EPT_CTRL_USED-1:0]};
    end
  end

  // count: software write wins, control write untouched
  always_ff @(posedge sys_clk) begin
    if (srst) begin
      count_reg <= EPT_COUNT_RST;
    end else if (wr_count) begin
      count_reg <= wb_dat_i[7:0];
    end else if (inc_tick) begin
      count_reg <= count_next;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (srst) begin
      period_reg <= EPT_PERIOD_RST;
    end else if (wr_per) begin
      period_reg <= wb_dat_i[7:0];
    end
  end

  always_ff @(posedge sys_clk) begin
    if (srst) begin
      ien_reg <= 1'b0;
    end else if (wr_ien) begin
      ien_reg <= wb_dat_i[0];
    end
  end

  // read mux; unmapped and write-only clear read as zero
  assign rdat_next = sel_ctrl  ? {24'h00_0000, ctrl_reg}   :
                     sel_count ? {24'h00_0000, count_reg}  :
                     sel_per   ? {24'h00_0000, period_reg} :
                     sel_stat  ? {31'h0000_0000, match_irq_flag} :
                     sel_ien   ? {31'h0000_0000, ien_reg}  : 32'h0000_0000;

  // single-wait-state ack, dropped the cycle after
  always_ff @(posedge sys_clk) begin
    if (srst) begin
      ack_reg  <= 1'b0;
      rdat_reg <= 32'h0000_0000;
    end else begin
      ack_reg  <= req;
      rdat_reg <= rdat_next;
    end
  end

  assign wb_ack_o = ack_reg;
  assign wb_dat_o = rdat_reg;
endmodule

// >>> sim/ept_timer_asserts.sv
module ept_timer_asserts
  import ept_pkg::*;
(
  // watched ports
  input wire logic        sys_clk,
  input wire logic        srst,
  input wire logic        wb_cyc_i,
  input wire logic        wb_stb_i,
  input wire logic        wb_we_i,
  input wire logic [4:0]  wb_adr_i,
  input wire logic [31:0] wb_dat_o,
  input wire logic        wb_ack_o,
  input wire logic        pwm_time_base
);
  timeunit 1ns / 1ps;
  default clocking @(posedge sys_clk); endclocking
  default disable iff (srst);
  wire logic rd = wb_ack_o && !wb_we_i;
  a_ack_single: assert property (wb_ack_o |=> !wb_ack_o)
    else $error("ack held too long");
  a_ack_answer: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o)
    else $error("request not answered");
  a_ack_cause: assert property (wb_ack_o |-> $past(wb_stb_i))
    else $error("ack without request");
  a_tick_spacing: assert property (pwm_time_base |=> !pwm_time_base [*3])
    else $error("ticks too close");
  a_upper_zero: assert property (rd |-> wb_dat_o[31:8] == 24'h00_0000)
    else $error("upper read bits set");
  a_ctrl_top: assert property (rd && wb_adr_i == 5'h00 |-> !wb_dat_o[7])
    else $error("control bit 7 set");
  a_clear_reads: assert property (rd && wb_adr_i == EPT_ADDR_ICLR |-> wb_dat_o == 32'h0000_0000)
    else $error("clear register readable");
  a_unmapped_zero: assert property (rd && wb_adr_i == 5'h18 |-> wb_dat_o == 32'h0000_0000)
    else $error("unmapped read not zero");
endmodule
bind ept_timer ept_timer_asserts chk_u (.sys_clk(sys_clk), .srst(srst), .wb_cyc_i(wb_cyc_i),
  .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_dat_o(wb_dat_o),
  .wb_ack_o(wb_ack_o), .pwm_time_base(pwm_time_base));

// >>> sim/ept_pwm_sink.sv
module ept_pwm_sink (
  // time base in, tally out
  input  wire logic        sys_clk,
  input  wire logic        srst,
  input  wire logic        pwm_time_base,
  output logic      [15:0] pulses
);
  timeunit 1ns / 1ps;
  always_ff @(posedge sys_clk) begin
    if (srst) begin
      pulses <= 16'h0000;
    end else if (pwm_time_base) begin
      pulses <= pulses + 16'h0001;
    end
  end
endmodule

// >>> sim/ept_timer_bench.sv
module ept_timer_bench import ept_pkg::*;;
  timeunit 1ns / 1ps;
  logic        sys_clk = 0, srst = 1, cyc = 0, we = 0, ack, pwm, irq;
  logic [4:0]  adr = 0;
  logic [31:0] wdat = 0, rdat, dat_o;
  logic [15:0] pulses, p0;
  int          failures = 0, checks = 0, n;
  ept_timer dut_u (.sys_clk(sys_clk), .srst(srst), .wb_cyc_i(cyc), .wb_stb_i(cyc), .wb_we_i(we),
    .wb_adr_i(adr), .wb_sel_i(4'h1), .wb_dat_i(wdat), .wb_dat_o(dat_o), .wb_ack_o(ack),
    .pwm_time_base(pwm), .irq(irq));
  ept_pwm_sink sink_u (.sys_clk(sys_clk), .srst(srst), .pwm_time_base(pwm), .pulses(pulses));
  initial begin
    forever #2 sys_clk = ~sys_clk;
  end
  task automatic complete_run();
    $display("checks %0d failures %0d", checks, failures);
    if (failures == 0 && checks > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask
  task automatic check(string what, logic [31:0] exp, logic [31:0] got);
    checks++;
    if (got !== exp) begin
      failures++;
      $display("unexpected %s exp %h got %h", what, exp, got);
    end
  endtask
  // bounded wait for a high sample at a rising edge
  task automatic wait_on(ref logic s);
    n = 0;
    do begin
      @(posedge sys_clk);
      n++;
    end while (s !== 1'b1 && n < 400);
    if (n == 400) begin
      failures++;
      complete_run();
    end
  endtask
  task automatic bus(logic w, logic [4:0] a, logic [31:0] d);
    cyc <= 1'b1;
    we <= w;
    adr <= a;
    wdat <= d;
    wait_on(ack);
    rdat = dat_o;
    cyc <= 1'b0;
    @(posedge sys_clk);
  endtask
  task automatic rd(logic [4:0] a, string what, logic [31:0] exp);
    bus(1'b0, a, 32'h0000_0000);
    check(what, exp, rdat);
  endtask
  // control write clears scalers, so the old setting's last tick has passed by return
  task automatic gap(logic [31:0] c, int exp);
    bus(1'b1, 5'(EPT_ADDR_CTRL), c);
    wait_on(pwm);
    wait_on(pwm);
    check("gap", 32'(exp), 32'(n));
  endtask
  initial begin
    repeat (6) @(posedge sys_clk);
    srst <= 1'b0;
    rd(5'(EPT_ADDR_CTRL), "ctrl", 32'h0000_0000);
    rd(5'(EPT_ADDR_COUNT), "count", 32'h0000_0000);
    rd(5'(EPT_ADDR_PERIOD), "period", 32'h0000_00FF);
    $display("test reset done");
    bus(1'b1, 5'(EPT_ADDR_PERIOD), 32'h0000_0000);
    for (int i = 0; i < 4; i++) begin
      gap(32'(4 + i), 4 << (2 * (i - i / 3)));
    end
    bus(1'b1, 5'(EPT_ADDR_PERIOD), 32'h0000_0002);
    gap(32'h0000_0004, 12);
    $display("test timing done");
    check("irq", 32'h0000_0000, 32'(irq));
    rd(5'(EPT_ADDR_STAT), "flag", 32'h0000_0001);
    bus(1'b1, EPT_ADDR_IEN, 32'h0000_0001);
    check("irq", 32'h0000_0001, 32'(irq));
    bus(1'b1, 5'(EPT_ADDR_PERIOD), 32'h0000_0000);
    bus(1'b1, 5'(EPT_ADDR_CTRL), 32'h0000_007C);
    // count may sit above the new period, so restart it from zero
    bus(1'b1, 5'(EPT_ADDR_COUNT), 32'h0000_0000);
    p0 = pulses;
    bus(1'b1, EPT_ADDR_ICLR, 32'h0000_0001);
    wait_on(irq);
    repeat (2) @(posedge sys_clk);
    check("posts", 32'h0000_0010, 32'(pulses - p0));
    $display("test interrupt done");
    bus(1'b1, 5'(EPT_ADDR_CTRL), 32'h0000_0083);
    rd(5'(EPT_ADDR_CTRL), "ctrl", 32'h0000_0003);
    rd(5'(EPT_ADDR_STAT), "flag", 32'h0000_0001);
    bus(1'b1, 5'(EPT_ADDR_COUNT), 32'h0000_0003);
    bus(1'b1, 5'(EPT_ADDR_CTRL), 32'h0000_0000);
    repeat (40) @(posedge sys_clk);
    rd(5'(EPT_ADDR_COUNT), "count", 32'h0000_0003);
    bus(1'b1, EPT_ADDR_ICLR, 32'h0000_0001);
    rd(5'(EPT_ADDR_STAT), "flag", 32'h0000_0000);
    check("irq", 32'h0000_0000, 32'(irq));
    rd(5'h18, "unmapped", 32'h0000_0000);
    $display("test registers done");
    complete_run();
  end
endmodule
